// [rtl/sbc_mode_pkg.sv]
// Constants, bus carriers and state layout of the SBC mode controller.
// Assumes a 250 MHz aclk and an AXI4-Lite master with 32-bit data.
package sbc_mode_pkg;
    // ------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } axil_req_t;
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic [1:0]        bresp;
        logic              bvalid;
        logic              arready;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              rvalid;
    } axil_rsp_t;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_HWCTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_WKLVL  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_WDTRIG = 8'h10;
    localparam int HW_FAILCNT = 0;
    localparam int HW_OVRST   = 1;
    localparam int HW_SEC     = 2;
    localparam int WK_CFG     = 0;
    localparam int WK_DEV     = 1;
    localparam int ST_POR     = 0;
    localparam int ST_OV      = 1;
    localparam int ST_UV      = 2;
    localparam int ST_BUV     = 3;
    localparam int ST_WARN    = 4;
    localparam int ST_FAIL    = 5;
    localparam int ST_MODE    = 8;
    localparam logic [2:0] HW_RESET = 3'h0;
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_SLEEP   = 2'h1;
    localparam logic [1:0] MODE_STOP    = 2'h2;
    localparam logic [1:0] MODE_SOFTRST = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS           = 4;
    localparam int RESET_DELAY_US   = 10;
    localparam int CFG_FILTER_US    = 1;
    localparam int LONG_WIN_MS      = 200;
    localparam int RD_CYC     = (RESET_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int FILT_CYC   = (CFG_FILTER_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int LW_CYC_DOC = LONG_WIN_MS * 1000000 / CLK_NS;
    localparam int RD_W   = 12;
    localparam int FILT_W = 8;
    localparam logic [RD_W-1:0]   RD_LAST   = RD_W'(RD_CYC - 1);
    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);
    // ------------------------------------------------------------
    // Modes and block state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INIT = 3'b000, ST_NORMAL = 3'b001, ST_STOP = 3'b010,
        ST_SLEEP = 3'b011, ST_RESTART = 3'b100, ST_FAILSAFE = 3'b101
    } sbc_state_t;
    typedef struct packed {
        sbc_state_t        st;
        logic              rst_n;
        logic [RD_W-1:0]   rd_cnt;
        logic [31:0]       lw_cnt;
        logic              lw_act;
        logic [FILT_W-1:0] f_cnt;
        logic              f_prev;
        logic              f_val;
        logic              f_ok;
        logic              cfg;
        logic              dev;
        logic [1:0]        mode_sel;
        logic              fcnt_sel;
        logic              ovrst;
        logic              sec_req;
        logic              por;
        logic              ov_f;
        logic              uv_f;
        logic              buv_f;
        logic              warn_f;
        logic              fail_out;
        logic              wd_once;
        logic              ov_prev;
        logic              ot_prev;
        logic              reg_en;
        logic              sec_en;
        logic              can_f;
        logic              pd_n;
        logic              aw_h;
        logic [ADDR_W-1:0] aw_a;
        logic              w_h;
        logic [31:0]       w_d;
        logic [3:0]        w_s;
        axil_rsp_t         rsp;
    } sbc_regs_t;
endpackage

// [rtl/sbc_mode_ctrl.sv]
// Operating-mode controller of a system basis chip with AXI4-Lite registers.
// Assumes supply monitors, watchdog timing and wake detect arrive as
// synchronous levels or pulses on aclk.
`timescale 1ns/1ps
module sbc_mode_ctrl
#(
    parameter int unsigned LONG_WIN_CYC = sbc_mode_pkg::LW_CYC_DOC
)
(
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // Register bus
    input  wire sbc_mode_pkg::axil_req_t bus_req,
    output      sbc_mode_pkg::axil_rsp_t bus_rsp,
    // Monitors and pins
    input  wire logic                    test_pin_high,
    input  wire logic                    irq_cfg_pin_in,
    input  wire logic                    main_undervolt,
    input  wire logic                    main_overvolt,
    input  wire logic                    battery_undervolt,
    input  wire logic                    main_warn_in,
    input  wire logic                    wake_event,
    input  wire logic                    overtemp,
    input  wire logic                    wd_fail_in,
    // Outputs
    output      logic                    reset_out_n,
    output      logic                    irq_cfg_pin_out,
    output      logic                    irq_cfg_pin_oe_n,
    output      logic                    main_regulator_en,
    output      logic                    secondary_regulator_en,
    output      logic                    can_normal_force,
    output      logic                    fail_output,
    output      logic                    dev_mode
);
    import sbc_mode_pkg::*;

    sbc_regs_t s;
    sbc_regs_t n;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // All decisions in one place so priority stays visible
    always_comb
    begin
        logic       wr_go;
        logic       rd_go;
        logic       wr_ok;
        logic       win;
        logic       rel;
        logic       wd_ev;
        logic       live;
        logic       go;
        logic       clr;
        logic [31:0] rv;
        sbc_state_t tgt;
        wr_go = 1'b0;
        rd_go = 1'b0;
        wr_ok = 1'b0;
        win   = 1'b0;
        rel   = 1'b0;
        wd_ev = 1'b0;
        live  = 1'b0;
        go    = 1'b0;
        clr   = 1'b0;
        rv    = 32'h0;
        tgt   = s.st;
        n     = s;
        // Write channels are taken in either order
        if (s.rsp.awready && bus_req.awvalid)
        begin
            n.aw_h = 1'b1;
            n.aw_a = bus_req.awaddr;
        end
        if (s.rsp.wready && bus_req.wvalid)
        begin
            n.w_h = 1'b1;
            n.w_d = bus_req.wdata;
            n.w_s = bus_req.wstrb;
        end
        if (s.rsp.bvalid && bus_req.bready)
            n.rsp.bvalid = 1'b0;
        if (s.rsp.rvalid && bus_req.rready)
            n.rsp.rvalid = 1'b0;
        wr_go = s.aw_h && s.w_h && !s.rsp.bvalid;
        rd_go = s.rsp.arready && bus_req.arvalid;
        // Read mux
        if (bus_req.araddr == OFS_MODE)
            rv[1:0] = s.mode_sel;
        else if (bus_req.araddr == OFS_HWCTRL)
        begin
            rv[HW_FAILCNT] = s.fcnt_sel;
            rv[HW_OVRST]   = s.ovrst;
            rv[HW_SEC]     = s.sec_req;
        end
        else if (bus_req.araddr == OFS_WKLVL)
        begin
            rv[WK_CFG] = s.cfg;
            rv[WK_DEV] = s.dev;
        end
        else if (bus_req.araddr == OFS_STATUS)
        begin
            rv[ST_POR]  = s.por;
            rv[ST_OV]   = s.ov_f;
            rv[ST_UV]   = s.uv_f;
            rv[ST_BUV]  = s.buv_f;
            rv[ST_WARN] = s.warn_f;
            rv[ST_FAIL] = s.fail_out;
            rv[ST_MODE+2:ST_MODE] = s.st;
        end
        if (rd_go)
        begin
            n.rsp.rvalid = 1'b1;
            n.rsp.rdata  = rv;
            n.rsp.rresp  = (bus_req.araddr == OFS_MODE || bus_req.araddr == OFS_HWCTRL
                            || bus_req.araddr == OFS_WKLVL || bus_req.araddr == OFS_STATUS
                            || bus_req.araddr == OFS_WDTRIG) ? RESP_OKAY : RESP_SLVERR;
        end
        // Write decode; only the low byte carries fields
        if (wr_go)
        begin
            n.aw_h = 1'b0;
            n.w_h  = 1'b0;
            n.rsp.bvalid = 1'b1;
            wr_ok = 1'b1;
            if (s.aw_a == OFS_MODE && s.w_s[0])
            begin
                // Stop takes Normal, Stop and soft reset; Sleep from Stop goes to Restart
                // Ignored while reset is low so Sleep and Fail-Safe hold
                if (!s.rst_n)
                    wr_ok = 1'b1;
                else if (s.w_d[1:0] == MODE_SOFTRST)
                begin
                    go  = 1'b1;
                    tgt = ST_INIT;
                end
                else if (s.w_d[1:0] == MODE_SLEEP)
                begin
                    go  = 1'b1;
                    tgt = (s.st == ST_STOP) ? ST_RESTART : ST_SLEEP;
                    n.mode_sel = MODE_SLEEP;
                end
                else if (s.w_d[1:0] == MODE_STOP)
                begin
                    go  = 1'b1;
                    tgt = ST_STOP;
                    n.mode_sel = MODE_STOP;
                end
                else
                begin
                    go  = 1'b1;
                    tgt = ST_NORMAL;
                    n.mode_sel = MODE_NORMAL;
                end
            end
            else if (s.aw_a == OFS_HWCTRL && s.w_s[0])
            begin
                // Configuration writes are dropped in Stop
                if (s.st != ST_STOP)
                begin
                    n.fcnt_sel = s.w_d[HW_FAILCNT];
                    n.ovrst    = s.w_d[HW_OVRST];
                    n.sec_req  = s.w_d[HW_SEC];
                end
            end
            else if (s.aw_a == OFS_STATUS && s.w_s[0])
                clr = 1'b1;
            else if (s.aw_a == OFS_WDTRIG)
            begin
                n.lw_act  = 1'b0;
                n.wd_once = 1'b0;
            end
            else if (s.aw_a != OFS_WKLVL)
                wr_ok = 1'b0;
            n.rsp.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        // Any command in Init once reset is released, legal or not, ends Init, except a soft reset write
        if ((wr_go || rd_go) && s.st == ST_INIT && s.rst_n && !go)
        begin
            go  = 1'b1;
            tgt = ST_NORMAL;
        end
        // Status flags: set beats clear
        n.por    = s.por    && !(clr && s.w_d[ST_POR]);
        n.ov_f   = (s.ov_f  && !(clr && s.w_d[ST_OV])) || (main_overvolt && !s.ov_prev);
        n.uv_f   = (s.uv_f  && !(clr && s.w_d[ST_UV])) || (s.rst_n && main_undervolt);
        n.buv_f  = (s.buv_f && !(clr && s.w_d[ST_BUV])) || (s.rst_n && battery_undervolt);
        n.warn_f = (s.warn_f && !(clr && s.w_d[ST_WARN])) || (s.rst_n && main_warn_in);
        n.fail_out = s.fail_out && !(clr && s.w_d[ST_FAIL]);
        n.ov_prev = main_overvolt;
        n.ot_prev = overtemp;
        // Pin filter runs only while the pull-down window is open
        win = !s.rst_n && (s.st == ST_INIT || s.por);
        if (!win)
        begin
            n.f_ok  = 1'b0;
            n.f_cnt = '0;
        end
        else if (irq_cfg_pin_in != s.f_prev)
        begin
            n.f_prev = irq_cfg_pin_in;
            n.f_cnt  = '0;
        end
        else if (s.f_cnt == FILT_LAST)
        begin
            n.f_val = s.f_prev;
            n.f_ok  = 1'b1;
        end
        else
            n.f_cnt = s.f_cnt + 1'b1;
        // Reset delay and release
        if (!s.rst_n && s.rd_cnt != RD_LAST)
            n.rd_cnt = s.rd_cnt + 1'b1;
        rel = !s.rst_n && s.rd_cnt == RD_LAST && !main_undervolt
              && (s.st == ST_INIT || s.st == ST_RESTART);
        if (rel)
        begin
            n.rst_n  = 1'b1;
            n.lw_act = 1'b1;
            n.lw_cnt = 32'h0;
            if (win)
                n.cfg = s.f_ok ? s.f_val : 1'b0;
            if (s.st == ST_INIT)
                n.dev = test_pin_high;
            if (s.st == ST_RESTART)
            begin
                go  = 1'b1;
                tgt = ST_NORMAL;
            end
        end
        // Long open window; frozen in development mode
        if (s.lw_act && !s.dev && n.lw_act)
            n.lw_cnt = s.lw_cnt + 32'h1;
        live = s.rst_n && (s.st == ST_INIT || s.st == ST_NORMAL || s.st == ST_STOP);
        // Wake and overtemperature recovery
        if ((s.st == ST_SLEEP || s.st == ST_FAILSAFE) && wake_event)
        begin
            go  = 1'b1;
            tgt = ST_RESTART;
        end
        if (s.st == ST_FAILSAFE && s.ot_prev && !overtemp)
        begin
            go  = 1'b1;
            tgt = ST_RESTART;
        end
        // Undervoltage reset
        if (live && main_undervolt)
        begin
            go  = 1'b1;
            tgt = ST_RESTART;
        end
        // Overvoltage reaction depends on the latched level
        if (live && main_overvolt && !s.ov_prev && s.ovrst)
        begin
            go         = 1'b1;
            n.fail_out = 1'b1;
            tgt  = s.cfg ? ST_RESTART : ST_FAILSAFE;
        end
        // Watchdog failure: external timing or missed long window
        wd_ev = live && !s.dev
                && (wd_fail_in || (s.lw_act && s.lw_cnt == 32'(LONG_WIN_CYC - 1)));
        if (wd_ev)
        begin
            go = 1'b1;
            if (s.fcnt_sel || s.wd_once)
            begin
                n.fail_out = 1'b1;
                n.wd_once = 1'b0;
                tgt = s.cfg ? ST_RESTART : ST_FAILSAFE;
            end
            else
            begin
                n.wd_once = 1'b1;
                tgt = ST_RESTART;
            end
        end
        // Mode entry side effects
        if (go)
        begin
            n.st = tgt;
            if (tgt == ST_RESTART || tgt == ST_SLEEP || tgt == ST_FAILSAFE)
            begin
                n.rst_n  = 1'b0;
                n.rd_cnt = '0;
                n.lw_act = 1'b0;
            end
            if (tgt == ST_RESTART || tgt == ST_FAILSAFE)
                n.mode_sel = MODE_NORMAL;
            if (tgt == ST_INIT)
            begin
                // Soft reset keeps reset released and restarts the window
                n.mode_sel = MODE_NORMAL;
                {n.sec_req, n.ovrst, n.fcnt_sel} = HW_RESET;
                n.lw_act  = 1'b1;
                n.lw_cnt  = 32'h0;
                n.wd_once = 1'b0;
            end
        end
        // Registered pin and supply controls
        n.reg_en = !(n.st == ST_SLEEP || n.st == ST_FAILSAFE);
        n.sec_en = n.dev || n.sec_req;
        n.can_f  = n.dev;
        n.pd_n   = !(!n.rst_n && (n.st == ST_INIT || n.por));
        n.rsp.awready = !n.aw_h && !n.rsp.bvalid;
        n.rsp.wready  = !n.w_h && !n.rsp.bvalid;
        n.rsp.arready = !n.rsp.rvalid;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Power-on: Init, reset asserted, pull-down on, power-on flag set
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s     <= '0;
            s.por <= 1'b1;
        end
        else
            s <= n;
    end

    // Outputs straight from state flops; irq_cfg_pin_out is tied low
    assign bus_rsp                = s.rsp;
    assign reset_out_n            = s.rst_n;
    assign irq_cfg_pin_out        = 1'b0;
    assign irq_cfg_pin_oe_n       = s.pd_n;
    assign main_regulator_en      = s.reg_en;
    assign secondary_regulator_en = s.sec_en;
    assign can_normal_force       = s.can_f;
    assign fail_output            = s.fail_out;
    assign dev_mode               = s.dev;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence restart_done_s;
        s.st == ST_RESTART && !s.rst_n && s.rd_cnt == RD_LAST && !main_undervolt;
    endsequence
    sequence quiet_s;
        !main_undervolt && !main_overvolt && !wd_fail_in
        && (s.dev || s.lw_cnt != 32'(LONG_WIN_CYC - 1));
    endsequence

    regulator_off_a: assert property ((s.st == ST_SLEEP || s.st == ST_FAILSAFE)
        |-> !main_regulator_en && !reset_out_n) else $error("regulator on in low mode");
    wake_restart_a: assert property (s.st == ST_SLEEP && wake_event
        |=> s.st == ST_RESTART && !reset_out_n) else $error("wake missed");
    restart_exit_a: assert property (restart_done_s
        |=> s.st == ST_NORMAL && reset_out_n) else $error("restart did not exit");
    failsafe_hold_a: assert property (s.st == ST_FAILSAFE && !wake_event && !(s.ot_prev && !overtemp)
        |=> s.st == ST_FAILSAFE) else $error("fail-safe left early");
    dev_force_a: assert property (dev_mode |-> can_normal_force && secondary_regulator_en
        && $stable(s.lw_cnt)) else $error("development mode not forced");
    mode_clear_a: assert property ($rose(s.st == ST_RESTART)
        |-> s.mode_sel == MODE_NORMAL) else $error("mode field not cleared");
    pulldown_win_a: assert property (s.st == ST_INIT && !reset_out_n
        |-> !irq_cfg_pin_oe_n) else $error("pull-down off in init");
    cfg_latch_a: assert property ($rose(reset_out_n) && !$past(s.pd_n)
        |-> s.cfg == ($past(s.f_ok) ? $past(s.f_val) : 1'b0)) else $error("bad latch");
    cfg_hold_a: assert property (reset_out_n && $past(reset_out_n)
        |-> $stable(s.cfg)) else $error("config changed");
    init_cmd_a: assert property (s.st == ST_INIT && reset_out_n && bus_rsp.arready
        && bus_req.arvalid ##0 quiet_s |=> s.st == ST_NORMAL) else $error("init kept");
    wd_fast_fail_a: assert property (s.st == ST_NORMAL && wd_fail_in && !s.dev && s.fcnt_sel && s.cfg
        && !main_undervolt |=> s.st == ST_RESTART && fail_output) else $error("bad wd reaction");
endmodule

// [rtl/README_unused.sv]
// Holds no logic; the whole mode controller sits in sbc_mode_ctrl.sv.

// [tb/cfg_pin_model.sv]
// Board side of the interrupt/config pin, optional pull-up fitted.
// Assumes the block's weak pull-down is on while oe_n is low.
`timescale 1ns/1ps
module cfg_pin_model
(
    // Clock and strap
    input  wire logic aclk,
    input  wire logic pullup_fit,
    // Block side of the pin
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output      logic pin_level
);
    logic wander = 1'b0;
    // Floating pin wanders so no stale level passes for a strap
    always_ff @(posedge aclk)
        wander <= ~wander;
    // External pull-up beats the weak pull-down
    assign pin_level = pullup_fit ? 1'b1 : (!pin_oe_n ? pin_out : wander);
endmodule

// [tb/tb.sv]
// Self-checking bench of the mode controller over AXI4-Lite.
// Assumes the package constants and a short long-window parameter.
`timescale 1ns/1ps
module tb;
    import sbc_mode_pkg::*;
    logic      aclk = 1'b0;
    logic      aresetn = 1'b0;
    axil_req_t req = '0;
    axil_rsp_t rsp;
    logic      tp = 1'b0, pu = 1'b1, ov = 1'b0, wk = 1'b0, wdf = 1'b0;
    logic      uv = 1'b0, buv = 1'b0, wrn = 1'b0, ot = 1'b0;
    logic      rst_n, p_out, p_oe_n, p_lvl, reg_en, sec_en, can_f, fail_o, dm;
    logic [31:0] d, v;
    logic [1:0]  r;
    int        errors = 0, checks = 0, seed = 73172;
    // 250 MHz clock
    always #2 aclk = ~aclk;
    sbc_mode_ctrl #(.LONG_WIN_CYC(400)) DUT (.aclk(aclk), .aresetn(aresetn),
        .bus_req(req), .bus_rsp(rsp), .test_pin_high(tp), .irq_cfg_pin_in(p_lvl),
        .main_undervolt(uv), .main_overvolt(ov), .battery_undervolt(buv),
        .main_warn_in(wrn), .wake_event(wk), .overtemp(ot), .wd_fail_in(wdf),
        .reset_out_n(rst_n), .irq_cfg_pin_out(p_out), .irq_cfg_pin_oe_n(p_oe_n),
        .main_regulator_en(reg_en), .secondary_regulator_en(sec_en),
        .can_normal_force(can_f), .fail_output(fail_o), .dev_mode(dm));
    cfg_pin_model board (.aclk(aclk), .pullup_fit(pu), .pin_out(p_out),
        .pin_oe_n(p_oe_n), .pin_level(p_lvl));
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task close_out;
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task tmo;
        errors++;
        close_out;
    endtask
    // Both channels offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] x);
        int n;
        n = 0;
        req.awaddr <= a;
        req.wdata <= x;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end
        while (rsp.bvalid !== 1'b1 && n < 60);
        r = rsp.bresp;
        if (n >= 60) tmo;
    endtask
    task rd(input logic [7:0] a);
        int n;
        n = 0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (rsp.arready) req.arvalid <= 1'b0;
        end
        while (rsp.rvalid !== 1'b1 && n < 60);
        d = rsp.rdata;
        r = rsp.rresp;
        if (n >= 60) tmo;
    endtask
    task wrst(input logic x, input int lim);
        for (int n = 0; n < lim && rst_n !== x; n++)
            @(posedge aclk);
        if (rst_n !== x) tmo;
    endtask
    task pulse_wd;
        wdf <= 1'b1;
        @(posedge aclk);
        wdf <= 1'b0;
    endtask
    // Power-on with strap and test pin, then leave Init by a read
    task rst(input logic p, input logic t);
        aresetn <= 1'b0;
        pu <= p;
        tp <= t;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("pulldown", 0, p_oe_n);
        chk("reset held", 0, rst_n);
        wrst(1'b1, 3000);
        rd(OFS_WKLVL);
        chk("config", {30'h0, t, p}, d);
        rd(OFS_STATUS);
        rd(OFS_STATUS);
        chk("state", 1, d[10:8]);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        req.bready = 1'b1;
        req.rready = 1'b1;
        rst(1'b1, 1'b0);
        wr(OFS_WDTRIG, 0);
        repeat (4)
        begin
            v = $random(seed);
            wr(OFS_HWCTRL, v);
            rd(OFS_HWCTRL);
            chk("hwctrl", v & 32'h7, d);
        end
        wr(OFS_HWCTRL, 32'h3);
        wr(OFS_MODE, {30'h0, MODE_STOP});
        rd(OFS_MODE);
        chk("mode", MODE_STOP, d);
        rd(8'h40);
        chk("unmapped", RESP_SLVERR, r);
        wr(OFS_MODE, 0);
        // Soft reset: back to Init with reset kept high, hardware bits cleared
        wr(OFS_MODE, {30'h0, MODE_SOFTRST});
        chk("soft reset keeps reset", 1, rst_n);
        rd(OFS_STATUS);
        chk("soft reset mode", 0, d[10:8]);
        rd(OFS_HWCTRL);
        chk("soft reset hwctrl", 0, d);
        wr(OFS_HWCTRL, 32'h3);
        wr(OFS_WDTRIG, 0);
        // POR cleared, strap removed: the config level must not relatch
        wr(OFS_STATUS, 32'h1);
        pu <= 1'b0;
        pulse_wd;
        wrst(1'b0, 8);
        chk("fail out", 1, fail_o);
        wrst(1'b1, 3000);
        rd(OFS_WKLVL);
        chk("config kept", 1, d[0]);
        rd(OFS_MODE);
        chk("mode cleared", 0, d);
        rd(OFS_STATUS);
        chk("restart exit", 1, d[10:8]);
        // Sleep cuts the regulator until a wake
        wr(OFS_MODE, {30'h0, MODE_SLEEP});
        wrst(1'b0, 8);
        chk("sleep reg off", 0, reg_en);
        wk <= 1'b1;
        @(posedge aclk);
        wk <= 1'b0;
        wrst(1'b1, 3000);
        // Undervolt restarts; battery-undervolt and warning flags stay untouched while reset is low
        uv <= 1'b1;
        wrst(1'b0, 8);
        buv <= 1'b1;
        wrn <= 1'b1;
        repeat (3) @(posedge aclk);
        {uv, buv, wrn} <= 3'h0;
        wrst(1'b1, 3000);
        rd(OFS_STATUS);
        chk("supply flags", 3'h1, d[4:2]);
        // No strap: missed window, then second failure
        rst(1'b0, 1'b0);
        wrst(1'b0, 500);
        chk("no fail yet", 0, fail_o);
        wrst(1'b1, 3000);
        pulse_wd;
        repeat (30) @(posedge aclk);
        chk("failsafe fail", 1, fail_o);
        chk("reg off", 0, reg_en);
        wk <= 1'b1;
        @(posedge aclk);
        wk <= 1'b0;
        wrst(1'b1, 3000);
        chk("reg on", 1, reg_en);
        wr(OFS_WDTRIG, 0);
        wr(OFS_HWCTRL, 32'h2);
        ov <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("ov reg off", 0, reg_en);
        rd(OFS_STATUS);
        chk("ov flag", 1, d[1]);
        ov <= 1'b0;
        // Fail-Safe holds while hot, leaves when overtemperature clears
        ot <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(OFS_STATUS);
        chk("failsafe held", 5, d[10:8]);
        ot <= 1'b0;
        wrst(1'b1, 3000);
        rd(OFS_STATUS);
        chk("ot exit", 1, d[10:8]);
        // Development mode ignores the missing trigger
        rst(1'b1, 1'b1);
        chk("can forced", 1, can_f);
        chk("sec on", 1, sec_en);
        chk("dev pin", 1, dm);
        repeat (500) @(posedge aclk);
        chk("no restart", 1, rst_n);
        close_out;
    end
endmodule
